/* File: hdl/asr_pkg.sv */
package asr_pkg;

    // register byte addresses
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_TX_CTL = 8'h00;
    localparam logic [7:0] OFF_RX_CTL = 8'h04;
    localparam logic [7:0] OFF_BAUD_CTL = 8'h08;
    localparam logic [7:0] OFF_DIV_LO = 8'h0c;
    localparam logic [7:0] OFF_DIV_HI = 8'h10;
    localparam logic [7:0] OFF_TX_DATA = 8'h14;
    localparam logic [7:0] OFF_RX_DATA = 8'h18;
    localparam logic [7:0] OFF_INT_CTL = 8'h1c;

    // tx_status_control fields
    localparam int TXC_NINE = 6;
    localparam int TXC_EN = 5;
    localparam int TXC_SYNC = 4;
    localparam int TXC_HIGH_SPEED_BAUD_SELECT = 2;
    localparam int TXC_TX_SHIFT_EMPTY = 1;
    localparam int TXC_D9 = 0;

    // rx_status_control fields
    localparam int RXC_SERIAL_PORT_ENABLE = 7;
    localparam int RXC_NINE = 6;
    localparam int RXC_CONTINUOUS_RECEIVE_ENABLE = 4;
    localparam int RXC_ADDRESS_DETECT_ENABLE = 3;
    localparam int RXC_FRAMING_ERROR_FLAG = 2;
    localparam int RXC_OVERRUN_ERROR_FLAG = 1;
    localparam int RXC_D9 = 0;

    // baud_control fields
    localparam int BDC_RXPOL = 5;
    localparam int BDC_TXPOL = 4;
    localparam int BDC_WIDE = 3;

    // interrupt control fields
    localparam int INT_TXIE = 0;
    localparam int INT_RXIE = 1;
    localparam int INT_PEIE = 2;
    localparam int INT_GIE = 3;
    localparam int INT_TXF = 4;
    localparam int INT_RXF = 5;

    // reset values
    localparam logic [7:0] RST_TX_CTL = 8'h00;
    localparam logic [7:0] RST_RX_CTL = 8'h00;
    localparam logic [7:0] RST_BAUD_CTL = 8'h00;
    localparam logic [7:0] RST_DIV = 8'h00;
    localparam logic [3:0] RST_INT_CTL = 4'h0;

    // oversampling
    localparam logic [3:0] OVS_LAST = 4'hf;
    localparam logic [3:0] OVS_SMP_A = 4'h7;
    localparam logic [3:0] OVS_SMP_B = 4'h8;
    localparam logic [3:0] OVS_SMP_C = 4'h9;
    localparam logic [1:0] LEGACY_PRESCALE = 2'h3;

    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [3:0]
    {
        RX_IDLE = 4'h1,
        RX_START = 4'h2,
        RX_DATA = 4'h4,
        RX_STOP = 4'h8
    } asr_rx_state_t;

endpackage : asr_pkg

/* File: hdl/asr_baud_gen.sv */
module asr_baud_gen
    import asr_pkg::*;
(
    // clock and reset
    input wire logic clock_i,
    input wire logic srst_i,
    // control
    input wire logic run_i,
    input wire logic legacy_i,
    input wire logic [15:0] divisor_i,
    // tick
    output logic tick_o
);
    logic [15:0] count_q;
    logic [1:0] pre_q;

    // tick is one cycle wide, period (divisor+1), times four in legacy mode
    always_ff @(posedge clock_i)
    begin
        if (srst_i || !run_i)
        begin
            count_q <= 16'h0000;
            pre_q <= 2'h0;
            tick_o <= 1'b0;
        end
        else if (count_q >= divisor_i)
        begin
            count_q <= 16'h0000;
            if (!legacy_i || pre_q == LEGACY_PRESCALE)
            begin
                pre_q <= 2'h0;
                tick_o <= 1'b1;
            end
            else
            begin
                pre_q <= pre_q + 2'h1;
                tick_o <= 1'b0;
            end
        end
        else
        begin
            count_q <= count_q + 16'h0001;
            tick_o <= 1'b0;
        end
    end
endmodule : asr_baud_gen

/* File: hdl/asr_top.sv */
// Notes on behaviour
// [R1] software sets divisor and speed bits first
// [R2] software clears sync and sets port enable
// [R3] ninth bit set marks an address character
// [R4] tx polarity bit inverts idle and data
// [R5] transmit enable sets tx empty flag
// [R6] tx flag with all enables raises irq
// [R7] software writes ninth bit before data
// [R8] tx data write starts a character
// [R9] recovery at sixteen ticks per bit
// [R10] full character enters fifo, sets flag
// [R11] two characters plus third start buffered
// [R12] receiver runs with continuous_receive_enable, async, serial_port_enable
// [R13] falling edge starts character, start is zero
// [R14] half-bit recheck, silent abort if high
// [R15] full bit to centres, majority, lsb first
// [R16] stop zero sets framing error
// [R17] rx data read pops oldest character
// [R18] overrun blocks further reception
// [R19] rx polarity bit inverts received data
// [R20] rx flag set while fifo unread, read-only
// [R21] rx flag tracks occupancy, irq needs enables
// [R22] frame: start, eight/nine data, stop high
// [R23] lsb first, shared format and rate
// [R24] tx flag set when enabled and empty
// [R25] third char on full fifo sets overrun; one ending in the cycle of an rx data read is dropped, no overrun
// [R26] majority of three centre samples
// [R27] oversample counter restarts on start edge
module asr_top
    import asr_pkg::*;
(
    // clock and reset
    input wire logic clock_i,
    input wire logic srst_i,
    // axi4-lite write address
    input wire logic [asr_pkg::ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    // axi4-lite read address
    input wire logic [asr_pkg::ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // serial pins
    input wire logic serial_input_pin_i,
    output logic serial_output_pin_o,
    output logic serial_output_oe_n_o,
    // interrupt request
    output logic irq_o
);
    logic [7:0] tx_ctl_q;
    logic [7:0] rx_ctl_q;
    logic [7:0] baud_ctl_q;
    logic [7:0] div_lo_q;
    logic [7:0] div_hi_q;
    logic [3:0] int_ctl_q;
    logic aw_hold_q;
    logic w_hold_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [7:0] wdata_q;
    logic wstrb_q;
    logic do_write;
    logic rd_take;
    logic [31:0] rd_word;
    logic rd_hit;
    logic serial_port_enable;
    logic rx_on;
    logic tick;
    logic [7:0] tx_hold_q;
    logic tx_hold_d9_q;
    logic tx_full_q;
    logic [10:0] tx_shift_q;
    logic [3:0] tx_bits_q;
    logic [3:0] tx_ovs_q;
    logic tx_busy_q;
    logic tx_flag;
    logic tx_load;
    logic sync1_q;
    logic sync2_q;
    logic line_prev_q;
    logic line;
    asr_rx_state_t rx_state_q;
    logic [3:0] rx_ovs_q;
    logic [3:0] rx_bits_q;
    logic [8:0] rx_shift_q;
    logic smp_a_q;
    logic smp_b_q;
    logic maj;
    logic centre;
    logic [9:0] fifo_q [2];
    logic fifo_wr_q;
    logic fifo_rd_q;
    logic [1:0] fifo_cnt_q;
    logic push;
    logic pop;
    logic [9:0] push_word;
    logic overrun_error_flag_q;
    logic stop_done;
    logic keep_char;

    assign serial_port_enable = rx_ctl_q[RXC_SERIAL_PORT_ENABLE];
    assign rx_on = rx_ctl_q[RXC_CONTINUOUS_RECEIVE_ENABLE] && !tx_ctl_q[TXC_SYNC] && serial_port_enable; // [R12]

    // axi write: address and data taken in either order
    assign s_axi_awready_o = !aw_hold_q && !s_axi_bvalid_o;
    assign s_axi_wready_o = !w_hold_q && !s_axi_bvalid_o;
    assign do_write = aw_hold_q && w_hold_q && !s_axi_bvalid_o;

    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= 8'h00;
            wstrb_q <= 1'b0;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid_i && s_axi_awready_o)
            begin
                aw_hold_q <= 1'b1;
                awaddr_q <= s_axi_awaddr_i;
            end
            if (s_axi_wvalid_i && s_axi_wready_o)
            begin
                w_hold_q <= 1'b1;
                wdata_q <= s_axi_wdata_i[7:0];
                wstrb_q <= s_axi_wstrb_i[0];
            end
            if (do_write)
            begin
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o <= (awaddr_q[1:0] == 2'h0 && awaddr_q <= OFF_INT_CTL) ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_bready_i)
            begin
                s_axi_bvalid_o <= 1'b0;
            end
        end
    end

    function automatic logic wr_hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
        wr_hit = (a == off);
    endfunction : wr_hit

    // control registers; status bits are not writable
    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            tx_ctl_q <= RST_TX_CTL;
            rx_ctl_q <= RST_RX_CTL;
            baud_ctl_q <= RST_BAUD_CTL;
            div_lo_q <= RST_DIV;
            div_hi_q <= RST_DIV;
            int_ctl_q <= RST_INT_CTL;
        end
        else if (do_write && wstrb_q)
        begin
            if (wr_hit(awaddr_q, OFF_TX_CTL))
                tx_ctl_q <= wdata_q & 8'h75;
            else if (wr_hit(awaddr_q, OFF_RX_CTL))
                rx_ctl_q <= wdata_q & 8'hd8;
            else if (wr_hit(awaddr_q, OFF_BAUD_CTL))
                baud_ctl_q <= wdata_q & 8'h38;
            else if (wr_hit(awaddr_q, OFF_DIV_LO))
                div_lo_q <= wdata_q;
            else if (wr_hit(awaddr_q, OFF_DIV_HI))
                div_hi_q <= wdata_q;
            else if (wr_hit(awaddr_q, OFF_INT_CTL))
                int_ctl_q <= wdata_q[3:0];
        end
    end

    // axi read: one cycle to rvalid, rx data read pops
    assign s_axi_arready_o = !s_axi_rvalid_o;
    assign rd_take = s_axi_arvalid_i && s_axi_arready_o;

    always_comb
    begin
        rd_word = 32'h0000_0000;
        rd_hit = 1'b1;
        if (s_axi_araddr_i == OFF_TX_CTL)
        begin
            rd_word[7:0] = tx_ctl_q;
            rd_word[TXC_TX_SHIFT_EMPTY] = !tx_busy_q;
        end
        else if (s_axi_araddr_i == OFF_RX_CTL)
        begin
            rd_word[7:0] = rx_ctl_q;
            rd_word[RXC_FRAMING_ERROR_FLAG] = (fifo_cnt_q != 2'h0) && fifo_q[fifo_rd_q][9];
            rd_word[RXC_OVERRUN_ERROR_FLAG] = overrun_error_flag_q;
            rd_word[RXC_D9] = (fifo_cnt_q != 2'h0) && fifo_q[fifo_rd_q][8];
        end
        else if (s_axi_araddr_i == OFF_BAUD_CTL)
            rd_word[7:0] = baud_ctl_q;
        else if (s_axi_araddr_i == OFF_DIV_LO)
            rd_word[7:0] = div_lo_q;
        else if (s_axi_araddr_i == OFF_DIV_HI)
            rd_word[7:0] = div_hi_q;
        else if (s_axi_araddr_i == OFF_TX_DATA)
            rd_word = 32'h0000_0000;
        else if (s_axi_araddr_i == OFF_RX_DATA)
            rd_word[7:0] = (fifo_cnt_q != 2'h0) ? fifo_q[fifo_rd_q][7:0] : 8'h00;
        else if (s_axi_araddr_i == OFF_INT_CTL)
        begin
            rd_word[3:0] = int_ctl_q;
            rd_word[INT_TXF] = tx_flag;
            rd_word[INT_RXF] = fifo_cnt_q != 2'h0; // [R20]
        end
        else
            rd_hit = 1'b0;
    end

    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= 32'h0000_0000;
            s_axi_rresp_o <= RESP_OKAY;
        end
        else if (rd_take)
        begin
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o <= rd_word;
            s_axi_rresp_o <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_rready_i)
        begin
            s_axi_rvalid_o <= 1'b0;
        end
    end

    // one 16x tick serves both directions
    asr_baud_gen u_baud (
        .clock_i(clock_i),
        .srst_i(srst_i),
        .run_i(serial_port_enable),
        .legacy_i(!tx_ctl_q[TXC_HIGH_SPEED_BAUD_SELECT] && !baud_ctl_q[BDC_WIDE]),
        .divisor_i(baud_ctl_q[BDC_WIDE] ? {div_hi_q, div_lo_q} : {8'h00, div_lo_q}),
        .tick_o(tick)
    ); // [R23]

    // transmitter
    assign tx_flag = tx_ctl_q[TXC_EN] && !tx_full_q; // [R5] [R24]
    assign tx_load = tx_full_q && !tx_busy_q && tx_ctl_q[TXC_EN] && serial_port_enable;
    assign irq_o = int_ctl_q[INT_GIE] && int_ctl_q[INT_PEIE]
        && ((int_ctl_q[INT_TXIE] && tx_flag) || (int_ctl_q[INT_RXIE] && fifo_cnt_q != 2'h0)); // [R6] [R21]

    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            tx_full_q <= 1'b0;
            tx_hold_q <= 8'h00;
            tx_hold_d9_q <= 1'b0;
        end
        else if (do_write && wstrb_q && wr_hit(awaddr_q, OFF_TX_DATA))
        begin
            // ninth bit sampled at the data write, so it must be set beforehand
            tx_full_q <= 1'b1; // [R8]
            tx_hold_q <= wdata_q;
            tx_hold_d9_q <= tx_ctl_q[TXC_D9]; // [R7]
        end
        else if (tx_load)
        begin
            tx_full_q <= 1'b0;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (srst_i || !serial_port_enable)
        begin
            tx_busy_q <= 1'b0;
            tx_shift_q <= 11'h7ff;
            tx_bits_q <= 4'h0;
            tx_ovs_q <= 4'h0;
        end
        else if (tx_load)
        begin
            tx_busy_q <= 1'b1;
            tx_ovs_q <= 4'h0;
            if (tx_ctl_q[TXC_NINE])
            begin
                tx_shift_q <= {1'b1, tx_hold_d9_q, tx_hold_q, 1'b0}; // [R3] [R22]
                tx_bits_q <= 4'hb;
            end
            else
            begin
                tx_shift_q <= {2'b11, tx_hold_q, 1'b0}; // [R22]
                tx_bits_q <= 4'ha;
            end
        end
        else if (tx_busy_q && tick)
        begin
            tx_ovs_q <= tx_ovs_q + 4'h1;
            if (tx_ovs_q == OVS_LAST)
            begin
                tx_shift_q <= {1'b1, tx_shift_q[10:1]}; // [R23]
                tx_bits_q <= tx_bits_q - 4'h1;
                if (tx_bits_q == 4'h1)
                    tx_busy_q <= 1'b0;
            end
        end
    end

    // pin idles at mark while the port is off
    assign serial_output_pin_o = serial_port_enable ? (tx_shift_q[0] ^ baud_ctl_q[BDC_TXPOL]) : 1'b1; // [R4]
    assign serial_output_oe_n_o = !serial_port_enable;

    // receiver input synchroniser
    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
            line_prev_q <= 1'b1;
        end
        else
        begin
            sync1_q <= serial_input_pin_i;
            sync2_q <= sync1_q;
            line_prev_q <= line;
        end
    end

    assign line = sync2_q ^ baud_ctl_q[BDC_RXPOL]; // [R19]
    assign maj = (smp_a_q & smp_b_q) | (smp_a_q & line) | (smp_b_q & line); // [R26]
    assign centre = tick && rx_ovs_q == OVS_SMP_C;
    assign stop_done = rx_state_q == RX_STOP && centre;
    // address detect only filters in nine-bit mode
    assign keep_char = !(rx_ctl_q[RXC_ADDRESS_DETECT_ENABLE] && rx_ctl_q[RXC_NINE] && !rx_shift_q[8]);
    assign push = stop_done && keep_char && fifo_cnt_q != 2'h2 && !overrun_error_flag_q; // [R10]
    assign pop = rd_take && s_axi_araddr_i == OFF_RX_DATA && fifo_cnt_q != 2'h0; // [R17]
    assign push_word = {!maj, rx_ctl_q[RXC_NINE] ? rx_shift_q[8] : 1'b0,
        rx_ctl_q[RXC_NINE] ? rx_shift_q[7:0] : rx_shift_q[8:1]}; // [R16]

    always_ff @(posedge clock_i)
    begin
        if (srst_i || !rx_on)
        begin
            rx_state_q <= RX_IDLE;
            rx_ovs_q <= 4'h0;
            rx_bits_q <= 4'h0;
            rx_shift_q <= 9'h000;
            smp_a_q <= 1'b1;
            smp_b_q <= 1'b1;
        end
        else
        begin
            if (tick && rx_ovs_q == OVS_SMP_A)
                smp_a_q <= line;
            if (tick && rx_ovs_q == OVS_SMP_B)
                smp_b_q <= line;
            if (tick && rx_state_q != RX_IDLE)
                rx_ovs_q <= rx_ovs_q + 4'h1; // [R9]
            case (rx_state_q)
                RX_IDLE:
                begin
                    // overrun holds the receiver off
                    if (line_prev_q && !line && !overrun_error_flag_q) // [R13] [R18]
                    begin
                        rx_state_q <= RX_START;
                        rx_ovs_q <= 4'h0; // [R27]
                    end
                end
                RX_START:
                begin
                    if (centre)
                    begin
                        if (maj) // [R14]
                            rx_state_q <= RX_IDLE;
                        else
                        begin
                            rx_state_q <= RX_DATA;
                            rx_bits_q <= 4'h0;
                        end
                    end
                end
                RX_DATA:
                begin
                    if (centre)
                    begin
                        rx_shift_q <= {maj, rx_shift_q[8:1]}; // [R15]
                        rx_bits_q <= rx_bits_q + 4'h1;
                        if (rx_bits_q == (rx_ctl_q[RXC_NINE] ? 4'h8 : 4'h7))
                            rx_state_q <= RX_STOP;
                    end
                end
                RX_STOP:
                begin
                    if (centre)
                        rx_state_q <= RX_IDLE;
                end
                default:
                    rx_state_q <= RX_IDLE;
            endcase
        end
    end

    // two-entry fifo, kept across continuous_receive_enable clear, flushed by port disable
    always_ff @(posedge clock_i)
    begin
        if (srst_i || !serial_port_enable)
        begin
            fifo_q[0] <= 10'h000;
            fifo_q[1] <= 10'h000;
            fifo_wr_q <= 1'b0;
            fifo_rd_q <= 1'b0;
            fifo_cnt_q <= 2'h0;
        end
        else
        begin
            if (push)
            begin
                fifo_q[fifo_wr_q] <= push_word;
                fifo_wr_q <= !fifo_wr_q;
            end
            if (pop)
                fifo_rd_q <= !fifo_rd_q;
            if (push && !pop)
                fifo_cnt_q <= fifo_cnt_q + 2'h1; // [R11]
            else if (pop && !push)
                fifo_cnt_q <= fifo_cnt_q - 2'h1;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (srst_i || !rx_on)
            overrun_error_flag_q <= 1'b0;
        else if (stop_done && keep_char && fifo_cnt_q == 2'h2 && !pop)
            overrun_error_flag_q <= 1'b1; // [R25]
    end
endmodule : asr_top

/* File: test/asr_properties.sv */
module asr_properties
    import asr_pkg::*;
(
    // clock and reset
    input wire logic clock_i,
    input wire logic srst_i,
    // register bus
    input wire logic [asr_pkg::ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    input wire logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    input wire logic s_axi_wready_o,
    input wire logic [1:0] s_axi_bresp_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [asr_pkg::ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic [1:0] s_axi_rresp_o,
    input wire logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // serial and interrupt
    input wire logic serial_input_pin_i,
    input wire logic serial_output_pin_o,
    input wire logic serial_output_oe_n_o,
    input wire logic irq_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (srst_i);

    chk_reset_idle: assert property ($fell(srst_i) |-> serial_output_pin_o && serial_output_oe_n_o
        && !irq_o && !s_axi_bvalid_o && !s_axi_rvalid_o) else $error("outputs not idle after reset");
    chk_tx_released: assert property (serial_output_oe_n_o |-> serial_output_pin_o)
        else $error("released tx line not at mark");
    chk_write_latency: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
        && s_axi_wready_o |=> !s_axi_bvalid_o ##1 s_axi_bvalid_o) else $error("write answer late");
    chk_b_drop: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
        else $error("write answer not released");
    chk_b_blocks: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
        else $error("write taken during answer");
    chk_read_next: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o
        && s_axi_rdata_o[31:8] == 24'h0) else $error("read answer wrong");
    chk_r_blocks: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
        else $error("read taken during answer");
    chk_r_drop: assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o)
        else $error("read answer not released");

    cov_write: cover property (s_axi_bvalid_o && s_axi_bready_i);
    cov_read: cover property (s_axi_rvalid_o && s_axi_rready_i);
    cov_irq: cover property ($rose(irq_o));
endmodule : asr_properties

bind asr_top asr_properties asr_properties_i (.*);

/* File: test/asr_remote_node.sv */
module asr_remote_node #(
    parameter int BIT_CYC = 32
)
(
    // clock
    input wire logic clock_i,
    // line control
    input wire logic inv_i,
    input wire logic tx_line_i,
    output logic line_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic raw = 1'b1;
    logic [8:0] cap;
    logic [8:0] got_q [$];

    // idles at mark, low true when inverted
    assign line_o = raw ^ inv_i;

    task automatic send(input logic [7:0] d, input logic stop);
        logic [9:0] f;
        f = {stop, d, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            @(posedge clock_i);
            raw <= f[i];
            repeat (BIT_CYC - 1) @(posedge clock_i);
        end
        @(posedge clock_i);
        raw <= 1'b1;
    endtask : send

    // short low pulse, far below half a bit
    task automatic glitch(input int n);
        @(posedge clock_i);
        raw <= 1'b0;
        repeat (n) @(posedge clock_i);
        raw <= 1'b1;
    endtask : glitch

    // nine samples: eight data plus ninth bit or stop
    always
    begin
        @(negedge tx_line_i);
        repeat (BIT_CYC / 2) @(posedge clock_i);
        for (int i = 0; i < 9; i++)
        begin
            repeat (BIT_CYC) @(posedge clock_i);
            cap[i] = tx_line_i;
        end
        got_q.push_back(cap);
    end
endmodule : asr_remote_node

/* File: test/tb_top.sv */
module tb_top
    import asr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock_i = 1'b0;
    logic srst_i = 1'b1;
    logic [ADDR_W-1:0] s_axi_awaddr_i = 8'h00;
    logic [ADDR_W-1:0] s_axi_araddr_i = 8'h00;
    logic [31:0] s_axi_wdata_i = 32'h0;
    logic [3:0] s_axi_wstrb_i = 4'h1;
    logic s_axi_awvalid_i = 1'b0;
    logic s_axi_wvalid_i = 1'b0;
    logic s_axi_arvalid_i = 1'b0;
    logic s_axi_bready_i = 1'b1;
    logic s_axi_rready_i = 1'b1;
    logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
    logic [31:0] s_axi_rdata_o;
    logic serial_input_pin_i, serial_output_pin_o, serial_output_oe_n_o, irq_o;
    logic inv = 1'b0;
    logic [7:0] b;
    logic [7:0] int_en = 8'h00;
    logic [7:0] rst_offs [7] = '{OFF_RX_CTL, OFF_BAUD_CTL, OFF_DIV_LO, OFF_DIV_HI, OFF_TX_DATA,
        OFF_RX_DATA, OFF_INT_CTL};
    bit ovr = 1'b0;
    bit rx_on = 1'b1;
    int mismatches = 0;
    int cmp_count = 0;
    int unsigned seed = 17;
    int rxq [$];
    int txq [$];
    // pulled up while the port is released
    wire tx_line = serial_output_oe_n_o ? 1'b1 : serial_output_pin_o;

    asr_top asr_top_i (.*);
    asr_remote_node remote_i (.clock_i(clock_i), .inv_i(inv), .tx_line_i(tx_line), .line_o(serial_input_pin_i));

    always #50 clock_i = ~clock_i;

    function automatic logic [7:0] rnd8();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction : rnd8

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
        logic done;
        done = 1'b0;
        s_axi_awaddr_i <= a;
        s_axi_awvalid_i <= 1'b1;
        s_axi_wdata_i <= {24'h0, d};
        s_axi_wvalid_i <= 1'b1;
        while (!done)
        begin
            @(posedge clock_i);
            if (s_axi_awready_o)
                s_axi_awvalid_i <= 1'b0;
            if (s_axi_wready_o)
                s_axi_wvalid_i <= 1'b0;
            if (s_axi_bvalid_o)
            begin
                check("bresp", {30'h0, s_axi_bresp_o}, {30'h0, er});
                done = 1'b1;
            end
        end
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = RESP_OKAY);
        logic done;
        done = 1'b0;
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1'b1;
        while (!done)
        begin
            @(posedge clock_i);
            if (s_axi_arready_o)
                s_axi_arvalid_i <= 1'b0;
            if (s_axi_rvalid_o)
            begin
                check("rdata", s_axi_rdata_o, exp);
                check("rresp", {30'h0, s_axi_rresp_o}, {30'h0, er});
                done = 1'b1;
            end
        end
    endtask : rd

    // model: two entries, then overrun locks reception out
    task automatic rx_char(input logic [7:0] d, input logic stop);
        remote_i.send(d, stop);
        if (rx_on && !ovr)
        begin
            if (rxq.size() < 2)
                rxq.push_back({!stop, d});
            else
                ovr = 1'b1;
        end
    endtask : rx_char

    task automatic drain();
        int e;
        rd(OFF_INT_CTL, 32'({2'b0, rxq.size() > 0, 5'h10} | int_en));
        while (rxq.size() > 0)
        begin
            e = rxq.pop_front();
            rd(OFF_RX_CTL, 32'({5'h12, e[8], ovr, 1'b0}));
            rd(OFF_RX_DATA, 32'(e[7:0]));
        end
        rd(OFF_RX_DATA, 32'h0);
    endtask : drain

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run

    initial
    begin
        repeat (20000) @(posedge clock_i);
        mismatches++;
        complete_run();
    end

    initial
    begin
        repeat (8) @(posedge clock_i);
        srst_i <= 1'b0;
        foreach (rst_offs[i])
            rd(rst_offs[i], 32'h0);
        rd(8'h20, 32'h0, RESP_SLVERR);
        wr(8'h22, 8'hff, RESP_SLVERR);
        wr(OFF_DIV_LO, 8'h01);
        wr(OFF_RX_CTL, 8'h90);
        wr(OFF_TX_CTL, 8'h24);
        rd(OFF_INT_CTL, 32'h10);
        wr(OFF_INT_CTL, 8'h0d);
        check("irq", irq_o, 1'b1);
        wr(OFF_INT_CTL, 8'h0c);
        check("irq", irq_o, 1'b0);
        wr(OFF_BAUD_CTL, 8'h10);
        check("txidle", tx_line, 1'b0);
        wr(OFF_BAUD_CTL, 8'h00);
        // the polarity flip looked like a start edge to the remote
        repeat (400) @(posedge clock_i);
        remote_i.got_q.delete();
        for (int i = 0; i < 2; i++)
        begin
            b = rnd8();
            txq.push_back({1'b1, b});
            wr(OFF_TX_DATA, b);
        end
        rd(OFF_INT_CTL, 32'h0c);
        rd(OFF_TX_CTL, 32'h24);
        repeat (700) @(posedge clock_i);
        wr(OFF_TX_CTL, 8'h64);
        b = rnd8();
        txq.push_back({1'b0, b});
        wr(OFF_TX_DATA, b);
        repeat (400) @(posedge clock_i);
        wr(OFF_TX_CTL, 8'h24);
        rd(OFF_TX_CTL, 32'h26);
        while (txq.size() > 0)
            check("txchar", 32'(remote_i.got_q.pop_front()), 32'(txq.pop_front()));
        wr(OFF_INT_CTL, 8'h2e);
        int_en = 8'h0e;
        rx_char(rnd8(), 1'b1);
        rx_char(rnd8(), 1'b1);
        check("irq", irq_o, 1'b1);
        drain();
        check("irq", irq_o, 1'b0);
        wr(OFF_INT_CTL, 8'h00);
        int_en = 8'h00;
        repeat (4) rx_char(rnd8(), 1'b1);
        drain();
        wr(OFF_RX_CTL, 8'h80);
        ovr = 1'b0;
        rd(OFF_RX_CTL, 32'h80);
        wr(OFF_RX_CTL, 8'h90);
        rx_char(rnd8(), 1'b0);
        drain();
        remote_i.glitch(4);
        repeat (100) @(posedge clock_i);
        drain();
        rx_char(rnd8(), 1'b1);
        drain();
        wr(OFF_RX_CTL, 8'h80);
        rx_on = 1'b0;
        inv <= 1'b1;
        wr(OFF_BAUD_CTL, 8'h20);
        rx_char(rnd8(), 1'b1);
        wr(OFF_RX_CTL, 8'h90);
        rx_on = 1'b1;
        rx_char(rnd8(), 1'b1);
        drain();
        complete_run();
    end
endmodule : tb_top
